// *** pkg/cfs_consts.svh ***
/*
 * Offsets, field positions, reset values and widths of the core flag,
 * power status and program counter register group.
 * Assumes an 8-bit register port with one byte per offset.
 */
`ifndef CFS_CONSTS_SVH
`define CFS_CONSTS_SVH

// Register offsets
`define CFS_OFS_PC_LOW 8'h02
`define CFS_OFS_PC_LATCH 8'h0a
`define CFS_OFS_PWR_STATUS 8'h0c
`define CFS_OFS_IRQ_FLAGS 8'h0d
`define CFS_OFS_RST_CAUSE 8'h0e

// Widths
`define CFS_ADDR_W 8
`define CFS_DATA_W 8
`define CFS_PC_W 13
`define CFS_LATCH_W 5
`define CFS_JUMP_W 11

// Peripheral flag bit positions and sticky flag count
`define CFS_IRQ_EEPROM 7
`define CFS_IRQ_CMP 6
`define CFS_IRQ_RX 5
`define CFS_IRQ_TX 4
`define CFS_IRQ_CAPCOMP 2
`define CFS_IRQ_TMR2 1
`define CFS_IRQ_TMR1 0
`define CFS_IRQ_STICKY_N 5

// Power status bit positions
`define CFS_PWR_OSC_SEL 3
`define CFS_PWR_POR 1
`define CFS_PWR_BROWNOUT 0

// Reset cause bit positions
`define CFS_CAUSE_WATCHDOG 0
`define CFS_CAUSE_PIN 1

// Reset values
`define CFS_OSC_SEL_RST 1'b1
`define CFS_POR_RST 1'b0
`define CFS_BROWNOUT_RST 1'b0
`define CFS_STICKY_RST 5'h00
`define CFS_PC_RST 13'h0000
`define CFS_LATCH_RST 5'h00
`define CFS_BYTE_RST 8'h00

`endif

// *** pkg/cfs_pkg.sv ***
/*
 * Types shared by the core flag, power status and program counter group.
 * Assumes the constants header is on the include path.
 */
`include "cfs_consts.svh"

package cfs_pkg;

    // One register port request
    typedef struct packed {
        logic [`CFS_ADDR_W-1:0] addr;
        logic [`CFS_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } cfs_bus_req_t;

    // Reset sources, one-cycle pulses from the reset controller
    typedef struct packed {
        logic power_on;
        logic brownout;
        logic ext_pin;
        logic watchdog;
    } cfs_reset_evt_t;

    // Sticky peripheral events, one-cycle pulses, msb first
    typedef struct packed {
        logic eeprom;
        logic comparator;
        logic capcomp;
        logic timer2;
        logic timer1;
    } cfs_periph_evt_t;

    // Branch request from instruction execution
    typedef struct packed {
        logic advance;
        logic jump;
        logic [`CFS_JUMP_W-1:0] target;
    } cfs_branch_t;

endpackage : cfs_pkg

// *** src/cfs_core_regs.sv ***
/*
 * Core register group: peripheral interrupt flags, power and reset
 * status with oscillator select, reset cause flags and program counter.
 * Assumes a single-cycle register port on sys_clk_i, reset source pulses
 * and peripheral events from logic on sys_clk_i, and one asynchronous
 * power-on style reset on rstn_i.
 */
`timescale 1ns/10ps

module cfs_core_regs
    import cfs_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Register port
    input wire logic [`CFS_ADDR_W-1:0] reg_addr_i,
    input wire logic [`CFS_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [`CFS_DATA_W-1:0] reg_rdata_o,
    // Reset sources and configuration
    input wire cfs_reset_evt_t reset_evt_i,
    input wire logic brownout_detect_enable_i,
    input wire logic resistor_osc_mode_i,
    // Peripheral events
    input wire cfs_periph_evt_t periph_evt_i,
    input wire logic serial_rx_full_i,
    input wire logic serial_tx_empty_i,
    // Instruction flow
    input wire cfs_branch_t branch_i,
    // Outputs to the core
    output logic [`CFS_DATA_W-1:0] peripheral_irq_flags_o,
    output logic [`CFS_PC_W-1:0] pc_o,
    output logic osc_freq_select_o,
    output logic osc_ext_resistor_o
);

    cfs_bus_req_t req;

    logic wr_pc_low;
    logic wr_latch;
    logic wr_pwr;
    logic wr_flags;
    logic wr_cause;
    logic any_reset;

    logic osc_freq_select_ff;
    logic por_flag_ff;
    logic brownout_flag_ff;
    logic watchdog_cause_ff;
    logic pin_cause_ff;
    logic osc_ext_resistor_ff;
    logic [`CFS_DATA_W-1:0] reg_rdata_ff;
    logic [`CFS_DATA_W-1:0] nxt_rdata;
    logic [`CFS_DATA_W-1:0] pwr_status_val;
    logic [`CFS_DATA_W-1:0] cause_val;
    logic [`CFS_DATA_W-1:0] flags_val;
    logic [`CFS_PC_W-1:0] pc_val;
    logic [`CFS_LATCH_W-1:0] latch_val;

    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    // Write decode
    assign wr_pc_low = req.wr && (req.addr == `CFS_OFS_PC_LOW);
    assign wr_latch = req.wr && (req.addr == `CFS_OFS_PC_LATCH);
    assign wr_pwr = req.wr && (req.addr == `CFS_OFS_PWR_STATUS);
    assign wr_flags = req.wr && (req.addr == `CFS_OFS_IRQ_FLAGS);
    assign wr_cause = req.wr && (req.addr == `CFS_OFS_RST_CAUSE);

    assign any_reset = reset_evt_i.power_on | reset_evt_i.brownout |
                       reset_evt_i.ext_pin | reset_evt_i.watchdog;

    cfs_irq_flags u_irq_flags (
        .sys_clk_i (sys_clk_i),
        .rstn_i (rstn_i),
        .wr_i (wr_flags),
        .wdata_i (req.wdata),
        .evt_i (periph_evt_i),
        .rx_full_i (serial_rx_full_i),
        .tx_empty_i (serial_tx_empty_i),
        .flags_o (flags_val)
    );

    // Upper counter bits have no register address of their own
    cfs_prog_counter u_prog_counter (
        .sys_clk_i (sys_clk_i),
        .rstn_i (rstn_i),
        .clear_i (any_reset),
        .low_wr_i (wr_pc_low),
        .latch_wr_i (wr_latch),
        .wdata_i (req.wdata),
        .branch_i (branch_i),
        .pc_o (pc_val),
        .latch_o (latch_val)
    );

    // Oscillator select survives every reset but the asynchronous one
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            osc_freq_select_ff <= `CFS_OSC_SEL_RST;
        end else if (wr_pwr) begin
            osc_freq_select_ff <= req.wdata[`CFS_PWR_OSC_SEL];
        end
    end

    // Resistor frequency applies only in resistor oscillator mode
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            osc_ext_resistor_ff <= 1'b0;
        end else begin
            osc_ext_resistor_ff <= osc_freq_select_ff & resistor_osc_mode_i;
        end
    end

    // Hardware clear beats a software set in the same cycle
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            por_flag_ff <= `CFS_POR_RST;
        end else if (reset_evt_i.power_on) begin
            por_flag_ff <= 1'b0;
        end else if (wr_pwr) begin
            por_flag_ff <= req.wdata[`CFS_PWR_POR];
        end
    end

    // A power-on pulse leaves this flag alone: its value is then undefined
    // and software must set it; with the detector off it is not qualified
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            brownout_flag_ff <= `CFS_BROWNOUT_RST;
        end else if (reset_evt_i.brownout && brownout_detect_enable_i) begin
            brownout_flag_ff <= 1'b0;
        end else if (wr_pwr) begin
            brownout_flag_ff <= req.wdata[`CFS_PWR_BROWNOUT];
        end
    end

    // Pin and watchdog causes, sticky until software writes zero
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            watchdog_cause_ff <= 1'b0;
            pin_cause_ff <= 1'b0;
        end else begin
            if (reset_evt_i.watchdog) begin
                watchdog_cause_ff <= 1'b1;
            end else if (wr_cause) begin
                watchdog_cause_ff <= req.wdata[`CFS_CAUSE_WATCHDOG];
            end
            if (reset_evt_i.ext_pin) begin
                pin_cause_ff <= 1'b1;
            end else if (wr_cause) begin
                pin_cause_ff <= req.wdata[`CFS_CAUSE_PIN];
            end
        end
    end

    // Unimplemented status bits stay zero
    always_comb begin
        pwr_status_val = `CFS_BYTE_RST;
        pwr_status_val[`CFS_PWR_OSC_SEL] = osc_freq_select_ff;
        pwr_status_val[`CFS_PWR_POR] = por_flag_ff;
        pwr_status_val[`CFS_PWR_BROWNOUT] = brownout_flag_ff;
        cause_val = `CFS_BYTE_RST;
        cause_val[`CFS_CAUSE_WATCHDOG] = watchdog_cause_ff;
        cause_val[`CFS_CAUSE_PIN] = pin_cause_ff;
    end

    // Read mux; unmapped offsets and idle cycles read zero
    always_comb begin
        nxt_rdata = `CFS_BYTE_RST;
        if (req.rd) begin
            unique case (req.addr)
                `CFS_OFS_PC_LOW: nxt_rdata = pc_val[`CFS_DATA_W-1:0];
                `CFS_OFS_PC_LATCH: nxt_rdata = {3'h0, latch_val};
                `CFS_OFS_PWR_STATUS: nxt_rdata = pwr_status_val;
                `CFS_OFS_IRQ_FLAGS: nxt_rdata = flags_val;
                `CFS_OFS_RST_CAUSE: nxt_rdata = cause_val;
                default: nxt_rdata = `CFS_BYTE_RST;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_ff <= `CFS_BYTE_RST;
        end else begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata_o = reg_rdata_ff;
    assign peripheral_irq_flags_o = flags_val;
    assign pc_o = pc_val;
    assign osc_freq_select_o = osc_freq_select_ff;
    assign osc_ext_resistor_o = osc_ext_resistor_ff;

endmodule : cfs_core_regs

// *** src/cfs_irq_flags.sv ***
/*
 * Peripheral interrupt flag register: five sticky event flags and two
 * serial buffer levels.
 * Assumes event pulses and serial levels come from logic on sys_clk_i.
 */
`timescale 1ns/10ps

module cfs_irq_flags
    import cfs_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Software write
    input wire logic wr_i,
    input wire logic [`CFS_DATA_W-1:0] wdata_i,
    // Events and levels
    input wire cfs_periph_evt_t evt_i,
    input wire logic rx_full_i,
    input wire logic tx_empty_i,
    // Register value
    output logic [`CFS_DATA_W-1:0] flags_o
);

    logic [`CFS_IRQ_STICKY_N-1:0] sticky_ff;
    logic [`CFS_IRQ_STICKY_N-1:0] evt_vec;
    logic [`CFS_IRQ_STICKY_N-1:0] wr_vec;
    logic serial_rx_full_flag_ff;
    logic serial_tx_empty_flag_ff;

    assign evt_vec = evt_i;
    assign wr_vec = {wdata_i[`CFS_IRQ_EEPROM], wdata_i[`CFS_IRQ_CMP],
                     wdata_i[`CFS_IRQ_CAPCOMP], wdata_i[`CFS_IRQ_TMR2],
                     wdata_i[`CFS_IRQ_TMR1]};

    // An event in the same cycle as a clearing write keeps the flag set
    genvar gi;
    generate
        for (gi = 0; gi < `CFS_IRQ_STICKY_N; gi++) begin : g_sticky
            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    sticky_ff[gi] <= 1'b0;
                end else if (evt_vec[gi]) begin
                    sticky_ff[gi] <= 1'b1;
                end else if (wr_i) begin
                    sticky_ff[gi] <= wr_vec[gi];
                end
            end
        end
    endgenerate

    // Serial flags mirror buffer state and ignore writes
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            serial_rx_full_flag_ff <= 1'b0;
            serial_tx_empty_flag_ff <= 1'b0;
        end else begin
            serial_rx_full_flag_ff <= rx_full_i;
            serial_tx_empty_flag_ff <= tx_empty_i;
        end
    end

    // Bit 3 reads zero
    assign flags_o = {sticky_ff[4], sticky_ff[3], serial_rx_full_flag_ff,
                      serial_tx_empty_flag_ff, 1'b0, sticky_ff[2],
                      sticky_ff[1], sticky_ff[0]};

endmodule : cfs_irq_flags

// *** src/cfs_prog_counter.sv ***
/*
 * 13-bit program counter with its upper-bits latch.
 * Assumes all requests come from logic on sys_clk_i.
 */
`timescale 1ns/10ps

module cfs_prog_counter
    import cfs_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Synchronous clear from any reset source
    input wire logic clear_i,
    // Software writes
    input wire logic low_wr_i,
    input wire logic latch_wr_i,
    input wire logic [`CFS_DATA_W-1:0] wdata_i,
    // Instruction flow
    input wire cfs_branch_t branch_i,
    // State
    output logic [`CFS_PC_W-1:0] pc_o,
    output logic [`CFS_LATCH_W-1:0] latch_o
);

    logic [`CFS_PC_W-1:0] pc_ff;
    logic [`CFS_PC_W-1:0] nxt_pc;
    logic [`CFS_LATCH_W-1:0] pc_high_latch_ff;

    // Latch is a plain store; it never moves the counter by itself
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc_high_latch_ff <= `CFS_LATCH_RST;
        end else if (latch_wr_i) begin
            pc_high_latch_ff <= wdata_i[`CFS_LATCH_W-1:0];
        end
    end

    // Priority: clear, low-byte write, jump, advance
    always_comb begin
        nxt_pc = pc_ff;
        if (clear_i) begin
            nxt_pc = `CFS_PC_RST;
        end else if (low_wr_i) begin
            nxt_pc = {pc_high_latch_ff, wdata_i};
        end else if (branch_i.jump) begin
            nxt_pc = {pc_high_latch_ff[4:3], branch_i.target};
        end else if (branch_i.advance) begin
            // Carries into the upper bits; only the add to the low byte does not
            nxt_pc = pc_ff + 13'h0001;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc_ff <= `CFS_PC_RST;
        end else begin
            pc_ff <= nxt_pc;
        end
    end

    assign pc_o = pc_ff;
    assign latch_o = pc_high_latch_ff;

endmodule : cfs_prog_counter

// *** verification/cfs_core_model.sv ***
/*
 * Stand-in for instruction execution and the reset controller.
 * Assumes calls are made one at a time from the testbench.
 */
`timescale 1ns/10ps

module cfs_core_model
    import cfs_pkg::*;
(
    // Clock
    input wire logic sys_clk_i,
    // Requests to the register group
    output cfs_branch_t branch_o,
    output cfs_reset_evt_t reset_evt_o
);
    initial begin
        branch_o = '0;
        reset_evt_o = '0;
    end

    // Target is scrambled when idle so a stale jump address is never reused
    task automatic flow(input logic jmp, input logic [10:0] tgt);
        @(posedge sys_clk_i);
        branch_o <= {~jmp, jmp, tgt};
        @(posedge sys_clk_i);
        branch_o <= {2'b00, ~tgt};
        #1;
    endtask : flow

    task automatic rst_src(input logic [3:0] src);
        @(posedge sys_clk_i);
        reset_evt_o <= src;
        @(posedge sys_clk_i);
        reset_evt_o <= 4'h0;
        #1;
    endtask : rst_src
endmodule : cfs_core_model

// *** verification/cfs_core_regs_monitor.sv ***
/*
 * Port checker for the core register group.
 * Assumes it is bound into cfs_core_regs; one clock, async low reset.
 */
`timescale 1ns/10ps
`include "cfs_consts.svh"

module cfs_core_regs_monitor
    import cfs_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Register port
    input wire logic [`CFS_ADDR_W-1:0] reg_addr_i,
    input wire logic [`CFS_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [`CFS_DATA_W-1:0] reg_rdata_o,
    // Sources and configuration
    input wire cfs_reset_evt_t reset_evt_i,
    input wire logic brownout_detect_enable_i,
    input wire logic resistor_osc_mode_i,
    input wire cfs_periph_evt_t periph_evt_i,
    input wire logic serial_rx_full_i,
    input wire logic serial_tx_empty_i,
    input wire cfs_branch_t branch_i,
    // Outputs
    input wire logic [`CFS_DATA_W-1:0] peripheral_irq_flags_o,
    input wire logic [`CFS_PC_W-1:0] pc_o,
    input wire logic osc_freq_select_o,
    input wire logic osc_ext_resistor_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_latch_wr;
        reg_wr_i && reg_addr_i == `CFS_OFS_PC_LATCH && reset_evt_i == 4'h0 ##1 !reg_wr_i;
    endsequence
    sequence s_low_wr;
        reg_wr_i && reg_addr_i == `CFS_OFS_PC_LOW && reset_evt_i == 4'h0;
    endsequence
    sequence s_jump;
        branch_i.jump && !reg_wr_i && reset_evt_i == 4'h0;
    endsequence

    rd_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not zero outside read cycle");
    evt_set_a: assert property (periph_evt_i != 5'h00 |=>
        ({peripheral_irq_flags_o[7:6], peripheral_irq_flags_o[2:0]} & $past(periph_evt_i))
        == $past(periph_evt_i)) else $error("event did not set its flag");
    flag_gap_a: assert property (peripheral_irq_flags_o[3] == 1'b0)
        else $error("flag bit 3 not zero");
    serial_mirror_a: assert property (1'b1 |=>
        peripheral_irq_flags_o[5:4] == $past({serial_rx_full_i, serial_tx_empty_i}))
        else $error("serial flags do not follow buffer levels");
    // Sticky flags survive any cycle without a software write to them
    sticky_hold_a: assert property (!(reg_wr_i && reg_addr_i == `CFS_OFS_IRQ_FLAGS)
        |=> (peripheral_irq_flags_o & $past(peripheral_irq_flags_o) & 8'hc7)
        == ($past(peripheral_irq_flags_o) & 8'hc7)) else $error("sticky flag dropped");
    pc_clear_a: assert property (reset_evt_i != 4'h0 |=> pc_o == 13'h0000)
        else $error("reset source did not clear pc");
    low_load_a: assert property (s_latch_wr ##1 s_low_wr |=>
        pc_o == {$past(reg_wdata_i[4:0], 3), $past(reg_wdata_i)})
        else $error("low byte write did not load pc from latch");
    jump_high_a: assert property (s_latch_wr ##1 s_jump |=>
        pc_o[12:11] == $past(reg_wdata_i[4:3], 3)) else $error("jump upper bits wrong");
    jump_low_a: assert property (s_jump |=> pc_o[10:0] == $past(branch_i.target))
        else $error("jump low bits wrong");
    pc_step_a: assert property (branch_i.advance && !branch_i.jump && !reg_wr_i
        && reset_evt_i == 4'h0 |=> pc_o == $past(pc_o) + 13'h0001)
        else $error("pc step wrong");
    stat_unimpl_a: assert property (reg_rd_i && reg_addr_i == `CFS_OFS_PWR_STATUS
        |=> reg_rdata_o[7:4] == 4'h0 && !reg_rdata_o[2]) else $error("status gap bits set");
    por_clear_a: assert property (reset_evt_i.power_on ##1 !reg_wr_i
        ##1 (reg_rd_i && reg_addr_i == `CFS_OFS_PWR_STATUS) |=> !reg_rdata_o[`CFS_PWR_POR])
        else $error("power-on flag not cleared");
    // Either register placement of the product agrees once both inputs rest
    osc_ext_a: assert property ($stable(osc_freq_select_o) && $stable(resistor_osc_mode_i)
        |-> osc_ext_resistor_o == (osc_freq_select_o && resistor_osc_mode_i))
        else $error("resistor oscillator select wrong");
endmodule : cfs_core_regs_monitor

// *** verification/testbench.sv ***
/*
 * Self-checking bench for the core register group.
 * Assumes the monitor and core model files are compiled first.
 */
`timescale 1ns/10ps
`include "cfs_consts.svh"

module testbench;
    import cfs_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic brownout_en = 1'b1;
    logic res_mode = 1'b0;
    logic rx_full = 1'b0;
    logic tx_empty = 1'b0;
    cfs_periph_evt_t pevt = '0;
    cfs_reset_evt_t revt;
    cfs_branch_t branch;
    logic [7:0] rdata;
    logic [7:0] flags;
    logic [12:0] pc;
    logic osc_sel;
    logic osc_ext;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;
    int pos[5] = '{0, 1, 2, 6, 7};

    cfs_core_regs i_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .reset_evt_i(revt), .brownout_detect_enable_i(brownout_en),
        .resistor_osc_mode_i(res_mode), .periph_evt_i(pevt), .serial_rx_full_i(rx_full),
        .serial_tx_empty_i(tx_empty), .branch_i(branch), .peripheral_irq_flags_o(flags),
        .pc_o(pc), .osc_freq_select_o(osc_sel), .osc_ext_resistor_o(osc_ext));
    cfs_core_model i_core (.sys_clk_i(sys_clk_i), .branch_o(branch), .reset_evt_o(revt));

    always #4 sys_clk_i = ~sys_clk_i;

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want) begin
            fails++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, want);
        end
    endtask : chk

    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
        #1;
    endtask : wrr

    task automatic rdchk(input logic [7:0] a, input logic [7:0] want);
        @(posedge sys_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1;
        chk(rdata, want);
    endtask : rdchk

    initial begin
        repeat (4) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        rdchk(`CFS_OFS_PWR_STATUS, 8'h08);
        rdchk(`CFS_OFS_IRQ_FLAGS, 8'h00);
        rdchk(`CFS_OFS_PC_LOW, 8'h00);
        rdchk(8'h55, 8'h00);
        $display("reset test done");
        wrr(`CFS_OFS_PWR_STATUS, 8'hff);
        rdchk(`CFS_OFS_PWR_STATUS, 8'h0b);
        i_core.rst_src(4'h8);
        rdchk(`CFS_OFS_PWR_STATUS, 8'h09);
        wrr(`CFS_OFS_PWR_STATUS, 8'h0b);
        i_core.rst_src(4'h4);
        rdchk(`CFS_OFS_PWR_STATUS, 8'h0a);
        wrr(`CFS_OFS_PWR_STATUS, 8'h0b);
        // With the detector off a brownout pulse must not clear the flag
        @(posedge sys_clk_i);
        brownout_en <= 1'b0;
        i_core.rst_src(4'h4);
        rdchk(`CFS_OFS_PWR_STATUS, 8'h0b);
        @(posedge sys_clk_i);
        brownout_en <= 1'b1;
        i_core.rst_src(4'h2);
        i_core.rst_src(4'h1);
        rdchk(`CFS_OFS_RST_CAUSE, 8'h03);
        wrr(`CFS_OFS_RST_CAUSE, 8'h00);
        rdchk(`CFS_OFS_RST_CAUSE, 8'h00);
        @(posedge sys_clk_i);
        res_mode <= 1'b1;
        wrr(`CFS_OFS_PWR_STATUS, 8'h03);
        chk(osc_sel, 1'b0);
        // A reset source pulse leaves the oscillator select alone
        i_core.rst_src(4'h2);
        chk(osc_sel, 1'b0);
        chk(osc_ext, 1'b0);
        wrr(`CFS_OFS_PWR_STATUS, 8'h0b);
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk(osc_ext, 1'b1);
        $display("status test done");
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk_i);
            pevt <= 5'h01 << i;
            @(posedge sys_clk_i);
            pevt <= '0;
            repeat (3) @(posedge sys_clk_i);
            #1;
            chk(flags, 8'h01 << pos[i]);
            wrr(`CFS_OFS_IRQ_FLAGS, 8'h00);
            chk(flags, 8'h00);
        end
        @(posedge sys_clk_i);
        rx_full <= 1'b1;
        tx_empty <= 1'b1;
        wrr(`CFS_OFS_IRQ_FLAGS, 8'h00);
        chk(flags, 8'h30);
        @(posedge sys_clk_i);
        rx_full <= 1'b0;
        wrr(`CFS_OFS_IRQ_FLAGS, 8'hff);
        rdchk(`CFS_OFS_IRQ_FLAGS, 8'hd7);
        @(posedge sys_clk_i);
        pevt <= 5'h01;
        addr <= `CFS_OFS_IRQ_FLAGS;
        wdata <= 8'h00;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        pevt <= '0;
        wr <= 1'b0;
        rdchk(`CFS_OFS_IRQ_FLAGS, 8'h11);
        $display("flag test done");
        wrr(`CFS_OFS_PC_LATCH, 8'h1f);
        wrr(`CFS_OFS_PC_LOW, 8'h10);
        chk(pc, 13'h1f10);
        rdchk(`CFS_OFS_PC_LOW, 8'h10);
        wrr(`CFS_OFS_PC_LATCH, 8'hff);
        rdchk(`CFS_OFS_PC_LATCH, 8'h1f);
        chk(pc, 13'h1f10);
        wrr(`CFS_OFS_PC_LATCH, 8'h10);
        i_core.flow(1'b1, 11'h005);
        chk(pc, 13'h1005);
        // Computed branch: the add to the low byte wraps, nothing carries upward
        wrr(`CFS_OFS_PC_LOW, 8'h05 + 8'hfe);
        chk(pc, 13'h1003);
        rdchk(`CFS_OFS_PC_LATCH, 8'h10);
        wrr(`CFS_OFS_PC_LATCH, 8'h1f);
        wrr(`CFS_OFS_PC_LOW, 8'hff);
        i_core.flow(1'b0, 11'h7ff);
        chk(pc, 13'h0000);
        i_core.flow(1'b0, 11'h2aa);
        i_core.rst_src(4'h1);
        chk(pc, 13'h0000);
        $display("pc test done");
        close_out();
    end
endmodule : testbench

bind cfs_core_regs cfs_core_regs_monitor i_mon (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reset_evt_i(reset_evt_i),
    .brownout_detect_enable_i(brownout_detect_enable_i),
    .resistor_osc_mode_i(resistor_osc_mode_i), .periph_evt_i(periph_evt_i),
    .serial_rx_full_i(serial_rx_full_i), .serial_tx_empty_i(serial_tx_empty_i),
    .branch_i(branch_i), .peripheral_irq_flags_o(peripheral_irq_flags_o), .pc_o(pc_o),
    .osc_freq_select_o(osc_freq_select_o), .osc_ext_resistor_o(osc_ext_resistor_o));
